// *** pegm_port.sv ***
`timescale 1ns/1ps
// Operation
// - data at 0x00, output enable at 0x04, function one at 0x08
// - function three, four, five at 0x10, 0x14, 0x18
// - open drain 0x28, pull up 0x2C, pull down 0x30, input 0x38
// - data bits 7-0 map to pins 7-0, cleared at reset
// - output enable bit per pin, 1 drives the pin, reset clears all
// - function one bits 1-6 pick serial channel 0 and 1 lines
// - function three bit n routes pin n to address bit 16+n
// - function four picks irq four/five/six and clear-to-send inputs
module pegm_port
  import pegm_pkg::*;
#(
  parameter int PINS = pegm_pkg::PEGM_PINS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [pegm_pkg::PEGM_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [pegm_pkg::PEGM_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [pegm_pkg::PEGM_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pins
  input wire logic [7:0] i_pin_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic [7:0] o_pull_up,
  output logic [7:0] o_pull_down,
  output logic [7:0] o_function_five,
  // peripheral side, toward the pins
  input wire logic i_serial_ch0_transmit,
  input wire logic i_serial_ch1_transmit,
  input wire logic i_serial_ch0_clock_out,
  input wire logic i_serial_ch0_clock_oe,
  input wire logic i_serial_ch1_clock_out,
  input wire logic i_serial_ch1_clock_oe,
  input wire logic [7:0] i_ext_address,
  // peripheral side, from the pins
  output logic o_serial_ch0_receive,
  output logic o_serial_ch1_receive,
  output logic o_serial_ch0_clock_in,
  output logic o_serial_ch1_clock_in,
  output logic o_ext_irq_four,
  output logic o_ext_irq_five,
  output logic o_ext_irq_six,
  output logic o_clear_to_send_ch0,
  output logic o_clear_to_send_ch1
);

  import pegm_pkg::*;

  initial begin
    if (PINS != 8) begin
      $error("pegm_port: the pin map is fixed at eight pins");
    end
    if (PEGM_ADDR_W != 6) begin
      $error("pegm_port: the offset decode needs a six-bit address");
    end
    if (PEGM_DATA_W < 8) begin
      $error("pegm_port: the data bus must carry one full byte");
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] pin_data;
  logic [7:0] output_enable;
  logic [7:0] function_select_one;
  logic [7:0] function_select_three;
  logic [7:0] function_select_four;
  logic [7:0] function_select_five;
  logic [7:0] open_drain_control;
  logic [7:0] pull_up_control;
  logic [7:0] pull_down_control;
  logic [7:0] input_enable;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire req = i_avs_read | i_avs_write;
  // accept on the second cycle: waitrequest drops one cycle after request
  wire accept = req & ~o_avs_waitrequest;
  // only byte lane 0 is wired: every register lives in bits 7:0
  wire wr_en = accept & i_avs_write & i_avs_byteenable[0];
  wire [7:0] wbyte = i_avs_writedata[7:0];

  wire hit_data = (i_avs_address == PEGM_OFS_PIN_DATA);
  wire hit_oe = (i_avs_address == PEGM_OFS_OUTPUT_ENABLE);
  wire hit_f1 = (i_avs_address == PEGM_OFS_FUNC_ONE);
  wire hit_f3 = (i_avs_address == PEGM_OFS_FUNC_THREE);
  wire hit_f4 = (i_avs_address == PEGM_OFS_FUNC_FOUR);
  wire hit_f5 = (i_avs_address == PEGM_OFS_FUNC_FIVE);
  wire hit_od = (i_avs_address == PEGM_OFS_OPEN_DRAIN);
  wire hit_pu = (i_avs_address == PEGM_OFS_PULL_UP);
  wire hit_pd = (i_avs_address == PEGM_OFS_PULL_DOWN);
  wire hit_ie = (i_avs_address == PEGM_OFS_INPUT_ENABLE);

  // reserved and unmapped offsets fall through to zero, writes dropped
  wire [7:0] next_pin_data =
    (wr_en & hit_data) ? (wbyte & PEGM_MASK_FULL) : pin_data;
  wire [7:0] next_output_enable =
    (wr_en & hit_oe) ? (wbyte & PEGM_MASK_FULL) : output_enable;
  wire [7:0] next_function_select_one =
    (wr_en & hit_f1) ? (wbyte & PEGM_MASK_FUNC_ONE) :
    function_select_one;
  wire [7:0] next_function_select_three =
    (wr_en & hit_f3) ? (wbyte & PEGM_MASK_FUNC_THREE) :
    function_select_three;
  wire [7:0] next_function_select_four =
    (wr_en & hit_f4) ? (wbyte & PEGM_MASK_FUNC_FOUR) :
    function_select_four;
  wire [7:0] next_function_select_five =
    (wr_en & hit_f5) ? (wbyte & PEGM_MASK_FUNC_FIVE) :
    function_select_five;
  wire [7:0] next_open_drain_control =
    (wr_en & hit_od) ? (wbyte & PEGM_MASK_FULL) : open_drain_control;
  wire [7:0] next_pull_up_control =
    (wr_en & hit_pu) ? (wbyte & PEGM_MASK_FULL) : pull_up_control;
  wire [7:0] next_pull_down_control =
    (wr_en & hit_pd) ? (wbyte & PEGM_MASK_FULL) : pull_down_control;
  wire [7:0] next_input_enable =
    (wr_en & hit_ie) ? (wbyte & PEGM_MASK_FULL) : input_enable;

  // ************************************************************
  // pin input synchroniser
  // ************************************************************
  // the pad is asynchronous: two stages before any logic reads it
  logic [7:0] pin_sync;

  pegm_sync #(
    .WIDTH(8)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_pin_in),
    .o_sync(pin_sync)
  );

  // a disabled input buffer reads low, whatever the pad does
  wire [7:0] pin_level = pin_sync & input_enable;

  // ************************************************************
  // alternate function mux
  // ************************************************************
  // overlap between function registers is software's to avoid
  wire [7:0] alt_sel = function_select_one | function_select_three |
    function_select_four;
  wire [7:0] port_sel = ~alt_sel;

  wire [7:0] f1_out;
  wire [7:0] f1_en;
  // function one sources per pin; receive pins never drive
  assign f1_out[0] = 1'b0;
  assign f1_out[PEGM_F1_CH0_RX] = 1'b0;
  assign f1_out[PEGM_F1_CH0_TX] = i_serial_ch0_transmit;
  assign f1_out[PEGM_F1_CH0_CLK] = i_serial_ch0_clock_out;
  assign f1_out[PEGM_F1_CH1_CLK] = i_serial_ch1_clock_out;
  assign f1_out[PEGM_F1_CH1_TX] = i_serial_ch1_transmit;
  assign f1_out[PEGM_F1_CH1_RX] = 1'b0;
  assign f1_out[7] = 1'b0;
  assign f1_en[0] = 1'b0;
  assign f1_en[PEGM_F1_CH0_RX] = 1'b0;
  assign f1_en[PEGM_F1_CH0_TX] = 1'b1;
  assign f1_en[PEGM_F1_CH0_CLK] = i_serial_ch0_clock_oe;
  assign f1_en[PEGM_F1_CH1_CLK] = i_serial_ch1_clock_oe;
  assign f1_en[PEGM_F1_CH1_TX] = 1'b1;
  assign f1_en[PEGM_F1_CH1_RX] = 1'b0;
  assign f1_en[7] = 1'b0;

  wire [7:0] alt_out;
  wire [7:0] alt_en;
  wire [7:0] want_out;
  wire [7:0] want_en;
  wire [7:0] next_pin_out;
  wire [7:0] next_pin_oe;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // address bus wins over serial, inputs-only functions never drive
      assign alt_out[gi] = function_select_three[gi] ? i_ext_address[gi] :
        f1_out[gi];
      assign alt_en[gi] = function_select_three[gi] |
        (function_select_one[gi] & f1_en[gi]);
      assign want_out[gi] = port_sel[gi] ? pin_data[gi] : alt_out[gi];
      assign want_en[gi] = port_sel[gi] ? output_enable[gi] :
        alt_en[gi];
      // open drain only ever pulls low
      assign next_pin_out[gi] = open_drain_control[gi] ? 1'b0 :
        want_out[gi];
      assign next_pin_oe[gi] = open_drain_control[gi] ?
        (want_en[gi] & ~want_out[gi]) : want_en[gi];
    end
  endgenerate

  // ************************************************************
  // peripheral inputs
  // ************************************************************
  // deselected serial receive inputs idle high, like an undriven line
  // clocks, interrupts and clear-to-send idle low when deselected
  wire next_ch0_rx = function_select_one[PEGM_F1_CH0_RX] ?
    pin_level[1] : 1'b1;
  wire next_ch1_rx = function_select_one[PEGM_F1_CH1_RX] ?
    pin_level[6] : 1'b1;
  wire next_ch0_clk = function_select_one[PEGM_F1_CH0_CLK] ?
    pin_level[3] : 1'b0;
  wire next_ch1_clk = function_select_one[PEGM_F1_CH1_CLK] ?
    pin_level[4] : 1'b0;
  wire next_irq_four = function_select_four[PEGM_F4_IRQ_FOUR] ?
    pin_level[0] : 1'b0;
  wire next_irq_five = function_select_four[PEGM_F4_IRQ_FIVE] ?
    pin_level[1] : 1'b0;
  wire next_irq_six = function_select_four[PEGM_F4_IRQ_SIX] ?
    pin_level[7] : 1'b0;
  wire next_cts_ch0 = function_select_four[PEGM_F4_CTS_CH0] ?
    pin_level[3] : 1'b0;
  wire next_cts_ch1 = function_select_four[PEGM_F4_CTS_CH1] ?
    pin_level[4] : 1'b0;

  // ************************************************************
  // read path
  // ************************************************************
  // driven port pins read back the latch, others the pad level
  wire [7:0] port_drive = output_enable & port_sel;
  wire [7:0] data_view = (pin_data & port_drive) |
    (pin_level & ~port_drive);

  wire [7:0] rd_byte =
    hit_data ? data_view :
    hit_oe ? output_enable :
    hit_f1 ? function_select_one :
    hit_f3 ? function_select_three :
    hit_f4 ? function_select_four :
    hit_f5 ? function_select_five :
    hit_od ? open_drain_control :
    hit_pu ? pull_up_control :
    hit_pd ? pull_down_control :
    hit_ie ? input_enable :
    8'h00;

  // latched in the wait cycle so the data stand at the accept edge
  wire [31:0] next_readdata = (req & o_avs_waitrequest & i_avs_read) ?
    {24'h000000, rd_byte} : o_avs_readdata;
  wire next_waitrequest = ~(req & o_avs_waitrequest);

  // ************************************************************
  // register file
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_data <= PEGM_RST_REG;
      output_enable <= PEGM_RST_REG;
      function_select_one <= PEGM_RST_REG;
      function_select_three <= PEGM_RST_REG;
      function_select_four <= PEGM_RST_REG;
      function_select_five <= PEGM_RST_REG;
      open_drain_control <= PEGM_RST_REG;
      pull_up_control <= PEGM_RST_REG;
      pull_down_control <= PEGM_RST_REG;
      input_enable <= PEGM_RST_REG;
    end else begin
      pin_data <= next_pin_data;
      output_enable <= next_output_enable;
      function_select_one <= next_function_select_one;
      function_select_three <= next_function_select_three;
      function_select_four <= next_function_select_four;
      function_select_five <= next_function_select_five;
      open_drain_control <= next_open_drain_control;
      pull_up_control <= next_pull_up_control;
      pull_down_control <= next_pull_down_control;
      input_enable <= next_input_enable;
    end
  end

  // ************************************************************
  // bus handshake
  // ************************************************************
  // waitrequest idles high, so no request is taken in its first cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= PEGM_RST_RDATA;
    end else begin
      o_avs_waitrequest <= next_waitrequest;
      o_avs_readdata <= next_readdata;
    end
  end

  // ************************************************************
  // registered pin and peripheral outputs
  // ************************************************************
  // one cycle of latency is traded for glitch-free pad drive
  // pull and function-five copies only leave the block for the pads
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_out <= PEGM_RST_REG;
      o_pin_oe <= PEGM_RST_REG;
      o_pull_up <= PEGM_RST_REG;
      o_pull_down <= PEGM_RST_REG;
      o_function_five <= PEGM_RST_REG;
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_pin_oe;
      o_pull_up <= pull_up_control;
      o_pull_down <= pull_down_control;
      o_function_five <= function_select_five;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_serial_ch0_receive <= 1'b1;
      o_serial_ch1_receive <= 1'b1;
      o_serial_ch0_clock_in <= 1'b0;
      o_serial_ch1_clock_in <= 1'b0;
      o_ext_irq_four <= 1'b0;
      o_ext_irq_five <= 1'b0;
      o_ext_irq_six <= 1'b0;
      o_clear_to_send_ch0 <= 1'b0;
      o_clear_to_send_ch1 <= 1'b0;
    end else begin
      o_serial_ch0_receive <= next_ch0_rx;
      o_serial_ch1_receive <= next_ch1_rx;
      o_serial_ch0_clock_in <= next_ch0_clk;
      o_serial_ch1_clock_in <= next_ch1_clk;
      o_ext_irq_four <= next_irq_four;
      o_ext_irq_five <= next_irq_five;
      o_ext_irq_six <= next_irq_six;
      o_clear_to_send_ch0 <= next_cts_ch0;
      o_clear_to_send_ch1 <= next_cts_ch1;
    end
  end

endmodule // pegm_port

// *** pegm_pkg.sv ***
package pegm_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int PEGM_ADDR_W = 6;
  localparam int PEGM_DATA_W = 32;
  localparam int PEGM_PINS = 8;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [5:0] PEGM_OFS_PIN_DATA = 6'h00;
  localparam logic [5:0] PEGM_OFS_OUTPUT_ENABLE = 6'h04;
  localparam logic [5:0] PEGM_OFS_FUNC_ONE = 6'h08;
  localparam logic [5:0] PEGM_OFS_RSVD_0C = 6'h0C;
  localparam logic [5:0] PEGM_OFS_FUNC_THREE = 6'h10;
  localparam logic [5:0] PEGM_OFS_FUNC_FOUR = 6'h14;
  localparam logic [5:0] PEGM_OFS_FUNC_FIVE = 6'h18;
  localparam logic [5:0] PEGM_OFS_RSVD_1C = 6'h1C;
  localparam logic [5:0] PEGM_OFS_RSVD_24 = 6'h24;
  localparam logic [5:0] PEGM_OFS_OPEN_DRAIN = 6'h28;
  localparam logic [5:0] PEGM_OFS_PULL_UP = 6'h2C;
  localparam logic [5:0] PEGM_OFS_PULL_DOWN = 6'h30;
  localparam logic [5:0] PEGM_OFS_RSVD_34 = 6'h34;
  localparam logic [5:0] PEGM_OFS_INPUT_ENABLE = 6'h38;

  // ************************************************************
  // implemented-bit masks
  // ************************************************************
  localparam logic [7:0] PEGM_MASK_FULL = 8'hFF;
  localparam logic [7:0] PEGM_MASK_FUNC_ONE = 8'h7E;
  localparam logic [7:0] PEGM_MASK_FUNC_THREE = 8'hFF;
  localparam logic [7:0] PEGM_MASK_FUNC_FOUR = 8'h9B;
  localparam logic [7:0] PEGM_MASK_FUNC_FIVE = 8'h9F;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PEGM_F1_CH0_RX = 1;
  localparam int PEGM_F1_CH0_TX = 2;
  localparam int PEGM_F1_CH0_CLK = 3;
  localparam int PEGM_F1_CH1_CLK = 4;
  localparam int PEGM_F1_CH1_TX = 5;
  localparam int PEGM_F1_CH1_RX = 6;
  localparam int PEGM_F4_IRQ_FOUR = 0;
  localparam int PEGM_F4_IRQ_FIVE = 1;
  localparam int PEGM_F4_CTS_CH0 = 3;
  localparam int PEGM_F4_CTS_CH1 = 4;
  localparam int PEGM_F4_IRQ_SIX = 7;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] PEGM_RST_REG = 8'h00;
  localparam logic [31:0] PEGM_RST_RDATA = 32'h00000000;

endpackage

// *** pegm_sync.sv ***
`timescale 1ns/1ps
module pegm_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  initial begin
    if (WIDTH < 1) begin
      $error("pegm_sync: WIDTH must be at least 1");
    end
  end

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage_one <= '0;
      o_sync <= '0;
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end

endmodule // pegm_sync

// *** pegm_port_chk.sv ***
`timescale 1ns/1ps
// ********************
// port block checker
// ********************
module pegm_port_chk
  import pegm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [pegm_pkg::PEGM_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [pegm_pkg::PEGM_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [pegm_pkg::PEGM_DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pull_up,
  input wire logic [7:0] o_function_five,
  input wire logic o_serial_ch0_receive,
  input wire logic o_serial_ch1_receive
);
  wire logic [7:0] wd = i_avs_writedata[7:0];
  wire logic rd_ok = i_avs_read && !o_avs_waitrequest;
  wire logic wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_done;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_wait; s_req |=> s_done; endproperty
  a_wait: assert property (p_wait)
    else $error("wait state count wrong");
  property p_hi; rd_ok |-> o_avs_readdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi)
    else $error("upper read bits not zero");
  property p_rsvd;
    rd_ok && i_avs_address inside {6'h0C, 6'h1C, 6'h20, 6'h24, 6'h34, 6'h3C}
      |-> o_avs_readdata == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unmapped offset reads nonzero");
  property p_f1;
    rd_ok && i_avs_address == 6'h08 |-> (o_avs_readdata[7:0] & 8'h81) == 8'h00;
  endproperty
  a_f1: assert property (p_f1)
    else $error("function one spare bits set");
  property p_f4;
    rd_ok && i_avs_address == 6'h14 |-> (o_avs_readdata[7:0] & 8'h64) == 8'h00;
  endproperty
  a_f4: assert property (p_f4)
    else $error("function four spare bits set");
  // pull copies trail the register by one cycle, hence two edges
  property p_pu;
    wr_ok && i_avs_address == 6'h2C |-> ##2 o_pull_up == $past(wd, 2);
  endproperty
  a_pu: assert property (p_pu)
    else $error("pull up pins not updated");
  property p_f5;
    wr_ok && i_avs_address == 6'h18
      |-> ##2 o_function_five == ($past(wd, 2) & 8'h9F);
  endproperty
  a_f5: assert property (p_f5)
    else $error("function five copy wrong");
  property p_rst;
    $fell(i_rst) |-> o_pin_oe == 8'h00 && o_pin_out == 8'h00
      && o_serial_ch0_receive && o_serial_ch1_receive;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pins not idle after reset");
endmodule // pegm_port_chk

bind pegm_port pegm_port_chk i_pegm_port_chk (.*);

// *** pegm_pad.sv ***
`timescale 1ns/1ps
// ********************
// board side of the pads
// ********************
module pegm_pad (
  input wire logic i_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pu,
  input wire logic [7:0] i_pd,
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_level
);
  logic [7:0] flip = 8'h00;
  // a floating pad toggles so a stale level never passes for a drive
  always @(posedge i_clk) flip <= ~flip;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (i_oe[n])
        o_level[n] = i_out[n];
      else if (i_ext_en[n])
        o_level[n] = i_ext[n];
      else if (i_pu[n] || i_pd[n])
        o_level[n] = i_pu[n];
      else
        o_level[n] = flip[n];
    end
  end
endmodule // pegm_pad

// *** tb.sv ***
`timescale 1ns/1ps
// ********************
// port block testbench
// ********************
module tb;
  import pegm_pkg::*;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [5:0] i_avs_address = 6'h00;
  logic i_avs_read = 1'h0;
  logic i_avs_write = 1'h0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [7:0] i_pin_in, o_pin_out, o_pin_oe, o_pull_up, o_pull_down;
  logic [7:0] o_function_five;
  logic i_serial_ch0_transmit = 1'h0, i_serial_ch1_transmit = 1'h0;
  logic i_serial_ch0_clock_out = 1'h0, i_serial_ch0_clock_oe = 1'h0;
  logic i_serial_ch1_clock_out = 1'h0, i_serial_ch1_clock_oe = 1'h0;
  logic [7:0] i_ext_address = 8'h00;
  logic o_serial_ch0_receive, o_serial_ch1_receive;
  logic o_serial_ch0_clock_in, o_serial_ch1_clock_in;
  logic o_ext_irq_four, o_ext_irq_five, o_ext_irq_six;
  logic o_clear_to_send_ch0, o_clear_to_send_ch1;
  logic [7:0] ext = 8'h00, ext_en = 8'h00, d, m, a, e, x;
  logic [31:0] q, r;
  int fails = 0, check_count = 0, seed = 45, cyc = 0;
  wire logic [7:0] ser_v = {o_serial_ch0_receive, o_serial_ch1_receive,
    o_serial_ch0_clock_in, o_serial_ch1_clock_in, o_pin_out[2],
    o_pin_out[5], o_pin_oe[3], o_pin_oe[4]};
  wire logic [7:0] irq_v = {3'h0, o_ext_irq_four, o_ext_irq_five,
    o_ext_irq_six, o_clear_to_send_ch0, o_clear_to_send_ch1};

  pegm_port i_pegm_port (.*);
  pegm_pad i_pegm_pad (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pu(o_pull_up), .i_pd(o_pull_down), .i_ext(ext), .i_ext_en(ext_en),
    .o_level(i_pin_in));

  always #2 i_clk = ~i_clk;

  // ********************
  // bus, compare and expectation helpers
  // ********************
  task automatic bus(input logic w, input logic [5:0] ad,
    input logic [31:0] dt, input logic [3:0] b);
    @(posedge i_clk);
    i_avs_address <= ad;
    i_avs_writedata <= dt;
    i_avs_byteenable <= b;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'h0);
    q = o_avs_readdata;
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [7:0] f_mask(input int k);
    case (k)
      32'h08: return 8'h7E;
      32'h14: return 8'h9B;
      32'h18: return 8'h9F;
      32'h0C, 32'h1C, 32'h20, 32'h24, 32'h34, 32'h3C: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic bit f_rsvd(input int k);
    return k inside {32'h0C, 32'h1C, 32'h20, 32'h24, 32'h34};
  endfunction

  function automatic logic [7:0] f_rd(input logic [7:0] d, m, a, x, e);
    return (d & m & ~a) | (x & a) | (e & ~m & ~a);
  endfunction

  function automatic logic [7:0] f_ser(input logic [7:0] e,
    input logic [5:0] s);
    return {e[1], e[6], s[1] ? s[3] : e[3], s[0] ? s[2] : e[4], s[5], s[4],
      s[1], s[0]};
  endfunction

  // ********************
  // watchdog and main sequence
  // ********************
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'h0;
    for (int k = 0; k < 64; k += 4) begin
      if (f_rsvd(k)) begin
        continue;
      end
      bus(1'h0, 6'(k), 32'h0, 4'hF);
      chk("reset value", 32'h0, q);
    end
    $display("reset test done");
    for (int k = 4; k < 64; k += 4) begin
      if (f_rsvd(k)) begin
        continue;
      end
      r = $random(seed);
      bus(1'h1, 6'(k), r, 4'hF);
      bus(1'h0, 6'(k), 32'h0, 4'hF);
      chk("register", 32'(r[7:0] & f_mask(k)), q);
      if (k inside {8, 16, 20, 24}) begin
        bus(1'h1, 6'(k), 32'h0, 4'hF);
      end
    end
    bus(1'h1, 6'h2C, 32'h5A, 4'hF);
    bus(1'h1, 6'h2C, 32'hA5, 4'h0);
    bus(1'h0, 6'h2C, 32'h0, 4'hF);
    chk("byte enable", 32'h5A, q);
    chk("pull up pins", 32'h5A, 32'(o_pull_up));
    $display("register test done");
    bus(1'h1, 6'h38, 32'hFF, 4'hF);
    bus(1'h1, 6'h28, 32'h0, 4'hF);
    bus(1'h1, 6'h08, 32'h0, 4'hF);
    bus(1'h1, 6'h14, 32'h0, 4'hF);
    for (int n = 0; n < 8; n++) begin
      d = 8'($random(seed));
      m = (n == 1) ? 8'hFF : 8'($random(seed));
      a = (n == 0) ? 8'h00 : (n == 7) ? 8'hFF : 8'($random(seed));
      e = 8'($random(seed));
      x = 8'($random(seed));
      bus(1'h1, 6'h10, 32'(a), 4'hF);
      bus(1'h1, 6'h00, 32'(d), 4'hF);
      bus(1'h1, 6'h04, 32'(m), 4'hF);
      i_ext_address <= x;
      ext <= e;
      ext_en <= ~m & ~a;
      repeat (4) @(posedge i_clk);
      r = 32'(((x & a) | (d & ~a)) & (m | a));
      chk("pin drive", r, 32'(o_pin_out & (m | a)));
      chk("pin enable", 32'(m | a), 32'(o_pin_oe));
      bus(1'h0, 6'h00, 32'h0, 4'hF);
      chk("pin data", 32'(f_rd(d, m, a, x, e)), q);
    end
    // last pass routes every pin to the address bus: open drain on top
    bus(1'h1, 6'h28, 32'hFF, 4'hF);
    bus(1'h1, 6'h30, 32'(e), 4'hF);
    repeat (4) @(posedge i_clk);
    chk("open drain out", 32'h0, 32'(o_pin_out));
    chk("open drain enable", {24'h0, ~x}, 32'(o_pin_oe));
    chk("pull down pins", 32'(e), 32'(o_pull_down));
    bus(1'h1, 6'h28, 32'h0, 4'hF);
    $display("pin test done");
    bus(1'h1, 6'h10, 32'h0, 4'hF);
    bus(1'h1, 6'h08, 32'h7E, 4'hF);
    repeat (4) begin
      r = $random(seed);
      e = 8'($random(seed));
      {i_serial_ch0_transmit, i_serial_ch1_transmit, i_serial_ch0_clock_out,
        i_serial_ch1_clock_out, i_serial_ch0_clock_oe,
        i_serial_ch1_clock_oe} <= r[5:0];
      ext <= e;
      ext_en <= {2'h1, 1'h0, ~r[0], ~r[1], 2'h1, 1'h0};
      repeat (5) @(posedge i_clk);
      chk("serial", 32'(f_ser(e, r[5:0])), 32'(ser_v));
    end
    bus(1'h1, 6'h08, 32'h0, 4'hF);
    repeat (4) @(posedge i_clk);
    chk("receive idle", 32'h3, 32'(ser_v[7:6]));
    $display("serial test done");
    bus(1'h1, 6'h14, 32'h9B, 4'hF);
    ext_en <= 8'h9B;
    for (int n = 0; n < 5; n++) begin
      e = (n == 0) ? 8'hFF : 8'($random(seed));
      ext <= e;
      repeat (5) @(posedge i_clk);
      chk("irq select", 32'({e[0], e[1], e[7], e[3], e[4]}),
        32'(irq_v));
    end
    bus(1'h1, 6'h14, 32'h0, 4'hF);
    repeat (4) @(posedge i_clk);
    chk("irq idle", 32'h0, 32'(irq_v));
    $display("irq test done");
    conclude();
  end
endmodule // tb
